//--- design/sweep_pkg.sv
// constants, register map and state layout of the impedance sweep sequencer
package sweep_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL_HI = 8'h80;
  localparam logic [7:0] ADDR_CTRL_LO = 8'h81;
  localparam logic [7:0] ADDR_START_HI = 8'h82;
  localparam logic [7:0] ADDR_START_MID = 8'h83;
  localparam logic [7:0] ADDR_START_LO = 8'h84;
  localparam logic [7:0] ADDR_STEP_HI = 8'h85;
  localparam logic [7:0] ADDR_STEP_MID = 8'h86;
  localparam logic [7:0] ADDR_STEP_LO = 8'h87;
  localparam logic [7:0] ADDR_NPTS_HI = 8'h88;
  localparam logic [7:0] ADDR_NPTS_LO = 8'h89;
  localparam logic [7:0] ADDR_SETTLE_HI = 8'h8a;
  localparam logic [7:0] ADDR_SETTLE_LO = 8'h8b;
  localparam logic [7:0] ADDR_FLAGS = 8'h8f;
  localparam logic [7:0] ADDR_REAL_HI = 8'h94;
  localparam logic [7:0] ADDR_REAL_LO = 8'h95;
  localparam logic [7:0] ADDR_IMAG_HI = 8'h96;
  localparam logic [7:0] ADDR_IMAG_LO = 8'h97;

  // field positions
  localparam int FLAG_POINT_BIT = 2;
  localparam int FLAG_SWEEP_BIT = 3;
  localparam int CTRL_RANGE_LSB = 9;
  localparam int CTRL_GAIN_BIT = 8;
  localparam int ACC_LSB = 14;

  // command codes carried in the top nibble of the control high byte
  localparam logic [3:0] CMD_INIT = 4'h1;
  localparam logic [3:0] CMD_START = 4'h2;
  localparam logic [3:0] CMD_INC = 4'h3;
  localparam logic [3:0] CMD_REPEAT = 4'h4;
  localparam logic [3:0] CMD_RESET = 4'ha;
  localparam logic [3:0] CMD_STANDBY = 4'hb;

  // timing counts
  localparam logic [3:0] DDS_DIV_LAST = 4'hf;
  localparam logic [9:0] SMP_LAST = 10'h3ff;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_STANDBY = 3'b001,
    ST_INIT = 3'b011,
    ST_SETTLE = 3'b010,
    ST_MEASURE = 3'b110,
    ST_HOLD = 3'b111
  } state_t;

  typedef struct packed {
    state_t st;
    logic [15:0] ctrl;
    logic [23:0] start;
    logic [23:0] step;
    logic [15:0] npts;
    logic [15:0] settle;
    logic [23:0] freq;
    logic [26:0] phase;
    logic [3:0] div;
    logic [8:0] idx;
    logic [15:0] settle_cnt;
    logic [9:0] smp_cnt;
    logic signed [31:0] acc_re;
    logic signed [31:0] acc_im;
    logic [15:0] res_re;
    logic [15:0] res_im;
    logic point_done;
    logic sweep_done;
    logic signed [7:0] excite;
    logic gnd;
    logic [7:0] rdata;
  } core_t;

  localparam core_t CORE_RST = '0;

  // one period of a sine, 16 points, amplitude 127
  function automatic logic signed [7:0] sine_lut(input logic [3:0] p);
    logic signed [7:0] v;
    v = 8'sh00;
    case (p)
      4'h0: v = 8'sh00;
      4'h1: v = 8'sh31;
      4'h2: v = 8'sh5a;
      4'h3: v = 8'sh75;
      4'h4: v = 8'sh7f;
      4'h5: v = 8'sh75;
      4'h6: v = 8'sh5a;
      4'h7: v = 8'sh31;
      4'h8: v = 8'sh00;
      4'h9: v = -8'sh31;
      4'ha: v = -8'sh5a;
      4'hb: v = -8'sh75;
      4'hc: v = -8'sh7f;
      4'hd: v = -8'sh75;
      4'he: v = -8'sh5a;
      default: v = -8'sh31;
    endcase
    return v;
  endfunction : sine_lut

endpackage : sweep_pkg

//--- design/impedance_sweep_sequencer.sv
// impedance sweep sequencer: register file, sine source, settle timer and dft accumulator
// Function
// - step code is 24 bits, msb byte lowest
// - point count is 9 bits, max 511
// - flag bit 2 set when point finishes
// - no self advance; host reads results first
// - repeat command remeasures at same frequency
// - sweep done sets bit 3, blocks increments
// - standby grounds excitation and response
// - initialize drives start frequency, no measuring
// - wait programmed excitation cycles before sampling
// - bits d10 d9 pick excitation range
// - bit d8 picks receive gain five/one
// - accumulate 1024 products with cos, -sin
// - results in two 16-bit twos complement
// - 27-bit phase accumulator, top three zero
// - start frequency 24 bits from 82h
// - reset command keeps sweep parameters
`timescale 1ns/10ps
module impedance_sweep_sequencer (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata,
  input wire logic signed [11:0] adc_sample,
  input wire logic adc_valid,
  output logic signed [7:0] excitation_out,
  output logic excitation_grounded,
  output logic response_grounded,
  output logic [1:0] excitation_range,
  output logic receive_gain_stage_x5
);

  sweep_pkg::core_t s_r;
  sweep_pkg::core_t s_nxt;

  logic [27:0] phase_sum;
  logic ctrl_wr;
  logic [3:0] cmd;
  logic set_pd;
  logic set_sd;
  logic signed [7:0] cos_v;
  logic signed [7:0] sin_v;
  logic signed [19:0] prod_re;
  logic signed [19:0] prod_im;
  logic signed [31:0] sum_re;
  logic signed [31:0] sum_im;
  logic last_point;
  logic dds_on;

  // upper three phase input bits are forced low
  assign phase_sum = {1'b0, s_r.phase} + {4'h0, s_r.freq};
  assign ctrl_wr = reg_we && (reg_addr == sweep_pkg::ADDR_CTRL_HI);
  assign cmd = reg_wdata[7:4];
  assign cos_v = sweep_pkg::sine_lut(s_r.phase[26:23] + 4'h4);
  assign sin_v = sweep_pkg::sine_lut(s_r.phase[26:23]);
  assign prod_re = adc_sample * cos_v;
  assign prod_im = -(adc_sample * sin_v);
  assign sum_re = s_r.acc_re + {{12{prod_re[19]}}, prod_re};
  assign sum_im = s_r.acc_im + {{12{prod_im[19]}}, prod_im};
  // 9-bit point count: bits above d8 are ignored
  assign last_point = ({1'b0, s_r.idx} + 10'h001) >= {1'b0, s_r.npts[8:0]};
  assign dds_on = (s_r.st != sweep_pkg::ST_IDLE) && (s_r.st != sweep_pkg::ST_STANDBY);

  always_comb begin
    s_nxt = s_r;
    set_pd = 1'b0;
    set_sd = 1'b0;

    // sine source ticks once per sixteen clocks, matching the clock/16 code formula
    s_nxt.div = s_r.div + 4'h1;
    if (!dds_on) begin
      s_nxt.phase = '0;
    end else if (s_r.div == sweep_pkg::DDS_DIV_LAST) begin
      s_nxt.phase = phase_sum[26:0];
    end
    s_nxt.excite = dds_on ? sin_v : 8'sh00;
    s_nxt.gnd = (s_r.st == sweep_pkg::ST_STANDBY);

    case (s_r.st)
      sweep_pkg::ST_SETTLE: begin
        // settling counts whole excitation periods, seen as phase wraps
        if (s_r.settle_cnt >= s_r.settle) begin
          s_nxt.st = sweep_pkg::ST_MEASURE;
          s_nxt.acc_re = '0;
          s_nxt.acc_im = '0;
          s_nxt.smp_cnt = '0;
        end else if (s_r.div == sweep_pkg::DDS_DIV_LAST && phase_sum[27]) begin
          s_nxt.settle_cnt = s_r.settle_cnt + 16'h0001;
        end
      end
      sweep_pkg::ST_MEASURE: begin
        if (adc_valid) begin
          s_nxt.acc_re = sum_re;
          s_nxt.acc_im = sum_im;
          s_nxt.smp_cnt = s_r.smp_cnt + 10'h001;
          if (s_r.smp_cnt == sweep_pkg::SMP_LAST) begin
            s_nxt.res_re = sum_re[sweep_pkg::ACC_LSB +: 16];
            s_nxt.res_im = sum_im[sweep_pkg::ACC_LSB +: 16];
            set_pd = 1'b1;
            set_sd = last_point;
            s_nxt.st = sweep_pkg::ST_HOLD;
          end
        end
      end
      default: begin
        // idle, standby, initialize and hold only move on a command
      end
    endcase

    if (set_pd) begin
      s_nxt.point_done = 1'b1;
    end
    if (set_sd) begin
      s_nxt.sweep_done = 1'b1;
    end

    if (ctrl_wr) begin
      case (cmd)
        sweep_pkg::CMD_INIT: begin
          s_nxt.st = sweep_pkg::ST_INIT;
          s_nxt.freq = s_r.start;
          s_nxt.phase = '0;
          s_nxt.idx = '0;
          s_nxt.point_done = set_pd;
          s_nxt.sweep_done = set_sd;
        end
        sweep_pkg::CMD_START: begin
          s_nxt.st = sweep_pkg::ST_SETTLE;
          s_nxt.settle_cnt = '0;
          s_nxt.idx = '0;
          s_nxt.point_done = set_pd;
          s_nxt.sweep_done = set_sd;
        end
        sweep_pkg::CMD_INC: begin
          // increments after the last point are dropped
          if (s_r.st == sweep_pkg::ST_HOLD && !s_r.sweep_done) begin
            s_nxt.freq = s_r.freq + s_r.step;
            s_nxt.idx = s_r.idx + 9'h001;
            s_nxt.st = sweep_pkg::ST_SETTLE;
            s_nxt.settle_cnt = '0;
            s_nxt.point_done = 1'b0;
          end
        end
        sweep_pkg::CMD_REPEAT: begin
          if (s_r.st == sweep_pkg::ST_HOLD) begin
            s_nxt.st = sweep_pkg::ST_SETTLE;
            s_nxt.settle_cnt = '0;
            s_nxt.point_done = 1'b0;
          end
        end
        sweep_pkg::CMD_STANDBY: begin
          s_nxt.st = sweep_pkg::ST_STANDBY;
        end
        sweep_pkg::CMD_RESET: begin
          // sweep parameters are left alone on purpose
          s_nxt.st = sweep_pkg::ST_IDLE;
          s_nxt.point_done = set_pd;
          s_nxt.sweep_done = set_sd;
        end
        default: begin
        end
      endcase
    end

    // register writes; multi-byte words are msb first at the lowest address
    if (reg_we) begin
      if (reg_addr == sweep_pkg::ADDR_CTRL_HI) begin
        s_nxt.ctrl[15:8] = reg_wdata;
      end else if (reg_addr == sweep_pkg::ADDR_CTRL_LO) begin
        s_nxt.ctrl[7:0] = reg_wdata;
      end else if (reg_addr == sweep_pkg::ADDR_START_HI) begin
        s_nxt.start[23:16] = reg_wdata;
      end else if (reg_addr == sweep_pkg::ADDR_START_MID) begin
        s_nxt.start[15:8] = reg_wdata;
      end else if (reg_addr == sweep_pkg::ADDR_START_LO) begin
        s_nxt.start[7:0] = reg_wdata;
      end else if (reg_addr == sweep_pkg::ADDR_STEP_HI) begin
        s_nxt.step[23:16] = reg_wdata;
      end else if (reg_addr == sweep_pkg::ADDR_STEP_MID) begin
        s_nxt.step[15:8] = reg_wdata;
      end else if (reg_addr == sweep_pkg::ADDR_STEP_LO) begin
        s_nxt.step[7:0] = reg_wdata;
      end else if (reg_addr == sweep_pkg::ADDR_NPTS_HI) begin
        s_nxt.npts[15:8] = reg_wdata;
      end else if (reg_addr == sweep_pkg::ADDR_NPTS_LO) begin
        s_nxt.npts[7:0] = reg_wdata;
      end else if (reg_addr == sweep_pkg::ADDR_SETTLE_HI) begin
        s_nxt.settle[15:8] = reg_wdata;
      end else if (reg_addr == sweep_pkg::ADDR_SETTLE_LO) begin
        s_nxt.settle[7:0] = reg_wdata;
      end
    end

    // read data answers one cycle after the strobe; unmapped reads give zero
    s_nxt.rdata = 8'h00;
    if (reg_re) begin
      if (reg_addr == sweep_pkg::ADDR_CTRL_HI) begin
        s_nxt.rdata = s_r.ctrl[15:8];
      end else if (reg_addr == sweep_pkg::ADDR_CTRL_LO) begin
        s_nxt.rdata = s_r.ctrl[7:0];
      end else if (reg_addr == sweep_pkg::ADDR_START_HI) begin
        s_nxt.rdata = s_r.start[23:16];
      end else if (reg_addr == sweep_pkg::ADDR_START_MID) begin
        s_nxt.rdata = s_r.start[15:8];
      end else if (reg_addr == sweep_pkg::ADDR_START_LO) begin
        s_nxt.rdata = s_r.start[7:0];
      end else if (reg_addr == sweep_pkg::ADDR_STEP_HI) begin
        s_nxt.rdata = s_r.step[23:16];
      end else if (reg_addr == sweep_pkg::ADDR_STEP_MID) begin
        s_nxt.rdata = s_r.step[15:8];
      end else if (reg_addr == sweep_pkg::ADDR_STEP_LO) begin
        s_nxt.rdata = s_r.step[7:0];
      end else if (reg_addr == sweep_pkg::ADDR_NPTS_HI) begin
        s_nxt.rdata = s_r.npts[15:8];
      end else if (reg_addr == sweep_pkg::ADDR_NPTS_LO) begin
        s_nxt.rdata = s_r.npts[7:0];
      end else if (reg_addr == sweep_pkg::ADDR_SETTLE_HI) begin
        s_nxt.rdata = s_r.settle[15:8];
      end else if (reg_addr == sweep_pkg::ADDR_SETTLE_LO) begin
        s_nxt.rdata = s_r.settle[7:0];
      end else if (reg_addr == sweep_pkg::ADDR_FLAGS) begin
        s_nxt.rdata[sweep_pkg::FLAG_POINT_BIT] = s_r.point_done;
        s_nxt.rdata[sweep_pkg::FLAG_SWEEP_BIT] = s_r.sweep_done;
      end else if (reg_addr == sweep_pkg::ADDR_REAL_HI) begin
        s_nxt.rdata = s_r.res_re[15:8];
      end else if (reg_addr == sweep_pkg::ADDR_REAL_LO) begin
        s_nxt.rdata = s_r.res_re[7:0];
      end else if (reg_addr == sweep_pkg::ADDR_IMAG_HI) begin
        s_nxt.rdata = s_r.res_im[15:8];
      end else if (reg_addr == sweep_pkg::ADDR_IMAG_LO) begin
        s_nxt.rdata = s_r.res_im[7:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_r <= sweep_pkg::CORE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign excitation_out = s_r.excite;
  assign excitation_grounded = s_r.gnd;
  assign response_grounded = s_r.gnd;
  assign excitation_range = s_r.ctrl[sweep_pkg::CTRL_RANGE_LSB +: 2];
  // d8 high selects unity gain, low selects five
  assign receive_gain_stage_x5 = ~s_r.ctrl[sweep_pkg::CTRL_GAIN_BIT];

  property p_step_bytes;
    @(posedge clk) disable iff (sys_rst)
      reg_we && reg_addr == sweep_pkg::ADDR_STEP_HI |=> s_r.step[23:16] == $past(reg_wdata);
  endproperty
  a_step_bytes: assert property (p_step_bytes) else $error("step msb byte not stored");

  property p_point_flag;
    @(posedge clk) disable iff (sys_rst)
      $rose(s_r.point_done) |-> $past(s_r.st) == sweep_pkg::ST_MEASURE
        && $past(s_r.smp_cnt) == 10'h3ff;
  endproperty
  a_point_flag: assert property (p_point_flag) else $error("point flag set early");

  property p_no_self_advance;
    @(posedge clk) disable iff (sys_rst)
      s_r.st == sweep_pkg::ST_HOLD && !ctrl_wr |=> s_r.st == sweep_pkg::ST_HOLD
        && $stable(s_r.freq);
  endproperty
  a_no_self_advance: assert property (p_no_self_advance) else $error("left hold alone");

  property p_repeat;
    @(posedge clk) disable iff (sys_rst)
      s_r.st == sweep_pkg::ST_HOLD && ctrl_wr && cmd == sweep_pkg::CMD_REPEAT
        |=> s_r.st == sweep_pkg::ST_SETTLE && $stable(s_r.freq) && !s_r.point_done;
  endproperty
  a_repeat: assert property (p_repeat) else $error("repeat changed frequency");

  property p_inc_blocked;
    @(posedge clk) disable iff (sys_rst)
      s_r.sweep_done && s_r.st == sweep_pkg::ST_HOLD && ctrl_wr && cmd == sweep_pkg::CMD_INC
        |=> s_r.st == sweep_pkg::ST_HOLD && $stable(s_r.freq);
  endproperty
  a_inc_blocked: assert property (p_inc_blocked) else $error("increment after sweep end");

  property p_standby_ground;
    @(posedge clk) disable iff (sys_rst)
      s_r.st == sweep_pkg::ST_STANDBY [*2] |-> excitation_grounded && response_grounded
        && excitation_out == 8'sh00;
  endproperty
  a_standby_ground: assert property (p_standby_ground) else $error("standby not grounded");

  property p_init_no_measure;
    @(posedge clk) disable iff (sys_rst)
      s_r.st == sweep_pkg::ST_INIT |=> $stable(s_r.res_re) && $stable(s_r.res_im)
        && !$rose(s_r.point_done);
  endproperty
  a_init_no_measure: assert property (p_init_no_measure) else $error("measured in init");

  property p_settle_before_sample;
    @(posedge clk) disable iff (sys_rst)
      $past(s_r.st) == sweep_pkg::ST_SETTLE && s_r.st == sweep_pkg::ST_MEASURE
        |-> $past(s_r.settle_cnt) >= $past(s_r.settle);
  endproperty
  a_settle_before_sample: assert property (p_settle_before_sample) else $error("short settle");

  property p_sample_count;
    @(posedge clk) disable iff (sys_rst)
      $past(s_r.st) == sweep_pkg::ST_MEASURE && s_r.st == sweep_pkg::ST_HOLD
        |-> $past(s_r.smp_cnt) == 10'h3ff && $past(adc_valid);
  endproperty
  a_sample_count: assert property (p_sample_count) else $error("wrong sample count");

  property p_reset_keeps;
    @(posedge clk) disable iff (sys_rst)
      ctrl_wr && cmd == sweep_pkg::CMD_RESET |=> $stable(s_r.start) && $stable(s_r.step)
        && $stable(s_r.npts) && s_r.st == sweep_pkg::ST_IDLE;
  endproperty
  a_reset_keeps: assert property (p_reset_keeps) else $error("reset lost parameters");

  property p_advance;
    @(posedge clk) disable iff (sys_rst)
      s_r.st == sweep_pkg::ST_HOLD && !s_r.sweep_done && ctrl_wr && cmd == sweep_pkg::CMD_INC
        |=> s_r.freq == $past(s_r.freq) + $past(s_r.step) && s_r.st == sweep_pkg::ST_SETTLE;
  endproperty
  a_advance: assert property (p_advance) else $error("advance did not step");

  property p_flag_clear_settle;
    @(posedge clk) disable iff (sys_rst)
      s_r.st == sweep_pkg::ST_SETTLE |-> !s_r.point_done;
  endproperty
  a_flag_clear_settle: assert property (p_flag_clear_settle) else $error("stale point flag");

endmodule : impedance_sweep_sequencer

//--- sim/adc_model.sv
// load and converter model that feeds samples back to the sequencer
`timescale 1ns/10ps
module adc_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic response_grounded,
  input wire logic signed [11:0] level,
  input wire logic [3:0] pace,
  output logic signed [11:0] adc_sample,
  output logic adc_valid
);
  logic [3:0] cnt_r;
  logic fire;

  // pace 0 stops the converter, 1 gives a sample every clock, larger values slow it down
  assign fire = (pace != 4'h0) && (cnt_r == 4'h0);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= 4'h0;
      adc_valid <= 1'b0;
      adc_sample <= 12'h000;
    end else begin
      cnt_r <= ((cnt_r + 4'h1) >= pace) ? 4'h0 : cnt_r + 4'h1;
      adc_valid <= fire;
      // between samples the bus shows junk, so a stale value can never pass for data
      if (!fire) begin
        adc_sample <= ~level;
      end else if (response_grounded) begin
        adc_sample <= 12'h000;
      end else begin
        adc_sample <= level;
      end
    end
  end
endmodule : adc_model

//--- sim/impedance_sweep_sequencer_tb.sv
// self-checking bench for the impedance sweep sequencer
`timescale 1ns/10ps
module impedance_sweep_sequencer_tb;
  typedef struct {
    logic [7:0] v;
    logic chk;
    string name;
  } note_t;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [7:0] reg_rdata;
  logic signed [11:0] adc_sample;
  logic adc_valid;
  logic signed [7:0] excitation_out;
  logic excitation_grounded;
  logic response_grounded;
  logic [1:0] excitation_range;
  logic receive_gain_stage_x5;
  logic signed [11:0] level = 12'h000;
  logic [3:0] pace = 4'h0;
  logic re_seen = 1'b0;
  logic [7:0] last_rd = 8'h00;
  logic [7:0] shadow [10];
  logic signed [7:0] e0;
  logic signed [7:0] emax;
  note_t note_q[$];
  int failures = 0;
  int check_count = 0;
  int cyc;
  int r;

  impedance_sweep_sequencer u_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .adc_sample(adc_sample), .adc_valid(adc_valid), .excitation_out(excitation_out),
    .excitation_grounded(excitation_grounded), .response_grounded(response_grounded),
    .excitation_range(excitation_range), .receive_gain_stage_x5(receive_gain_stage_x5));

  adc_model u_adc (.clk(clk), .sys_rst(sys_rst), .response_grounded(response_grounded),
    .level(level), .pace(pace), .adc_sample(adc_sample), .adc_valid(adc_valid));

  always #12.5 clk = ~clk;

  task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  // read data stands for one cycle only, so the monitor grabs it half a cycle after the edge
  always @(posedge clk) re_seen <= reg_re;
  always @(negedge clk) begin
    if (re_seen && note_q.size() > 0) begin
      note_t t;
      t = note_q.pop_front();
      last_rd = reg_rdata;
      if (t.chk) check(t.name, {8'h00, reg_rdata}, {8'h00, t.v});
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic bus_rd(input logic [7:0] a, input logic [7:0] e, input logic c, input string n);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    note_q.push_back('{e, c, n});
    @(posedge clk);
  endtask : bus_rd

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    bus_rd(a, e, 1'b1, n);
  endtask : rd

  task automatic rd16(input logic [7:0] a, input logic [15:0] e, input string n);
    rd(a, e[15:8], n);
    rd(a + 8'h01, e[7:0], n);
  endtask : rd16

  task automatic wait_flag(input logic [7:0] m, output int c);
    c = 0;
    last_rd = 8'h00;
    while (((last_rd & m) !== m) && c < 8000) begin
      bus_rd(8'h8f, 8'h00, 1'b0, "poll");
      c += 2;
    end
    if ((last_rd & m) !== m) begin
      failures++;
      $display("mismatch flag_wait expected %h seen %h", m, last_rd);
      summarize();
    end
  endtask : wait_flag

  // step code fixed at one full sine period over sixteen phase advances, two points
  task automatic cfg(input logic [23:0] f, input logic [15:0] s);
    logic [7:0] b [10];
    b = '{f[23:16], f[15:8], f[7:0], 8'h80, 8'h00, 8'h00, 8'h00, 8'h02, s[15:8], s[7:0]};
    for (int i = 0; i < 10; i++) wr(8'h82 + 8'(i), b[i]);
    wr(8'h80, 8'hb0);
    wr(8'h80, 8'h10);
  endtask : cfg

  initial begin
    void'($urandom(32'h1497));
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      shadow[i] = 8'($urandom);
      wr(8'h82 + 8'(i), shadow[i]);
    end
    wr(8'h80, 8'ha0);
    for (int i = 0; i < 10; i++) rd(8'h82 + 8'(i), shadow[i], "param");
    wr(8'h8f, 8'hff);
    rd(8'h8f, 8'h00, "flags_ro");
    rd(8'h8c, 8'h00, "unmapped");
    for (int i = 0; i < 8; i++) begin
      wr(8'h80, 8'hb0 | 8'(i));
      @(negedge clk);
      check("range", 16'(excitation_range), 16'(i[2:1]));
      check("gain_x5", 16'(receive_gain_stage_x5), 16'(!i[0]));
      check("grounded", {14'h0, excitation_grounded, response_grounded}, 16'h3);
      check("exc_idle", 16'(excitation_out), 16'h0);
      @(posedge clk);
    end
    // zero frequency keeps the cosine at full scale, so the real part is exact
    r = int'($urandom_range(255)) - 128;
    cfg(24'h000000, 16'h0000);
    level <= 12'(r * 16);
    pace <= 4'h3;
    wr(8'h80, 8'h20);
    wait_flag(8'h04, cyc);
    rd16(8'h94, 16'(r * 127), "real");
    rd16(8'h96, 16'h0000, "imag");
    repeat (300) @(posedge clk);
    rd(8'h8f, 8'h04, "hold");
    rd16(8'h94, 16'(r * 127), "real_hold");
    r = -r - 1;
    level <= 12'(r * 16);
    wr(8'h80, 8'h40);
    rd(8'h8f, 8'h00, "flag_clear");
    wait_flag(8'h04, cyc);
    rd16(8'h94, 16'(r * 127), "real_repeat");
    // after the step, 1024 back-to-back samples span whole periods and cancel out
    pace <= 4'h1;
    wr(8'h80, 8'h30);
    wait_flag(8'h0c, cyc);
    rd16(8'h94, 16'h0000, "real_step");
    rd16(8'h96, 16'h0000, "imag_step");
    wr(8'h80, 8'h30);
    rd(8'h8f, 8'h0c, "inc_ignored");
    cfg(24'h800000, 16'h0003);
    repeat (1100) @(posedge clk);
    rd(8'h8f, 8'h00, "init_no_measure");
    emax = 8'sh00;
    @(negedge clk);
    e0 = excitation_out;
    // the peak may fall in either half of the period, so both halves are scanned
    repeat (128) begin
      @(negedge clk);
      if (excitation_out > emax) emax = excitation_out;
    end
    check("half_turn", 16'(excitation_out), 16'(-e0));
    repeat (128) begin
      @(negedge clk);
      if (excitation_out > emax) emax = excitation_out;
    end
    check("full_turn", 16'(excitation_out), 16'(e0));
    check("peak", 16'(emax), 16'h007f);
    check("live", {14'h0, excitation_grounded, response_grounded}, 16'h0);
    @(posedge clk);
    wr(8'h80, 8'h20);
    wait_flag(8'h04, cyc);
    check("settle_time", 16'(cyc >= 1520 && cyc <= 1860), 16'h1);
    summarize();
  end
endmodule : impedance_sweep_sequencer_tb
